// >>> common/serial_adc_defines.vh
// constants shared by the serial converter sequencer and its helpers
`ifndef SERIAL_ADC_DEFINES_VH
`define SERIAL_ADC_DEFINES_VH

// ----------------------------------------------------------------------
// conversion_config field layout and reset value
// ----------------------------------------------------------------------
`define CFG_RESET          4'h0
`define CFG_LEN_RESET      2'b00
`define CFG_LEN_8          2'b01
`define CFG_LEN_16         2'b11
`define OUT_BITS_8         5'h08
`define OUT_BITS_12        5'h0c
`define OUT_BITS_16        5'h10

// ----------------------------------------------------------------------
// command_field codes (upper four bits of the command byte)
// ----------------------------------------------------------------------
`define CMD_LAST_INPUT     4'hd
`define CMD_PWRDN          4'he
`define CMD_RESERVED       4'hf

// ----------------------------------------------------------------------
// I/O cycle edge positions
// ----------------------------------------------------------------------
`define EDGE_CMD_DONE      5'h04
`define EDGE_LEN_TAKES     5'h06
`define EDGE_BYTE_DONE     5'h08

// ----------------------------------------------------------------------
// timing: times in ns, counts in clk_sys cycles
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      40
`define CS_DEBOUNCE_NS     120
`define CS_DEBOUNCE_CYC    ((`CS_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_HALF_NS        160
`define OSC_HALF_CYC       ((`OSC_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_OSC_HALVES    27
`define OSC_START_NS       25
`define OSC_START_CYC      ((`OSC_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC           (`OSC_START_CYC + `CONV_OSC_HALVES * `OSC_HALF_CYC)

`endif

// >>> rtl/pin_sync.v
// two-flop synchronisers for asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // pins and their synchronised copies
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta     <= INIT;
      sync_out <= INIT;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // pin_sync

`default_nettype wire

// >>> rtl/conversion_timer.v
// internal-oscillator conversion timing and result coding
`timescale 1ns/1ps
`default_nettype none
`include "serial_adc_defines.vh"

module conversion_timer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // control from the sequencer
  input  wire        start,
  input  wire        abort,
  input  wire        bipolar,
  // raw code from the analog core
  input  wire [11:0] core_result,
  // result towards the output buffer
  output reg         busy,
  output reg         done,
  output reg  [11:0] result
);

  localparam integer CONV_CYC_I = `CONV_CYC;
  localparam [7:0]   CONV_LAST  = CONV_CYC_I[7:0] - 8'h01;

  reg [7:0] count;
  reg       fmt;

  // count 13.5 oscillator periods plus start delay, then latch the code
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy   <= 1'b0;
      done   <= 1'b0;
      count  <= 8'h00;
      fmt    <= 1'b0;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;                                  // prior result kept
      end else if (start) begin
        busy  <= 1'b1;
        count <= 8'h00;
        fmt   <= bipolar;                              // format frozen at start
      end else if (busy) begin
        if (count == CONV_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
          // two's complement is the unsigned code with msb inverted
          result <= bipolar_code(core_result, fmt);
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end

  function [11:0] bipolar_code;
    input [11:0] code;
    input        signed_fmt;
    begin
      bipolar_code = {code[11] ^ signed_fmt, code[10:0]};
    end
  endfunction

endmodule // conversion_timer

`default_nettype wire

// >>> rtl/serial_adc_io_sequencer.v
// serial I/O and conversion sequencing of a multi-channel SAR converter
//
// Operation
// - Length 00 or 10: 12-bit output, conversion starts after twelfth falling edge.
// - Length 11: 16-bit output, four low bits zero, starts after sixteenth edge.
// - Length 01: upper 8 bits only, conversion starts after eighth falling edge.
// - New length governs current cycle from sixth rising edge.
// - Order bit picks msb- or lsb-first, effective from next cycle.
// - Format 0: unsigned coding, zeros low, ones high.
// - Format 1: two's complement, unsigned code with msb inverted.
// - Format applies to conversion started now, not to data shifting out.
// - Done flag high in reset and sampling, drops after final falling edge.
// - Done flag rises when result latched; first bit then appears if selected.
// - While converting with chip select low, data output is driven low.
// - Chip select high floats output; after debounce the I/O clock is ignored.
// - Debounced chip select low resets; host then holds clock low a while.
// - After chip select falls, each falling clock edge presents the next bit.
// - Chip select may abort conversion; prior result is kept for next cycle.
// - Command 1110 enters software power-down at fourth falling edge.
// - Power-down: no conversion, result kept, serial logic stays active.
// - Starts powered down; leaves on a valid input command, converts at end.
// - Sampling from fourth falling edge, held at last falling edge.
// - Auto power-down after conversion, resumed when chip select goes active.
// - Upper command bits select inputs 0..10, test voltages, power-down, reserved.
// - Reset clears configuration and sets done flag; first result is invalid.
// - Conversion lasts 13.5 oscillator periods plus start delay after I/O cycle.
`timescale 1ns/1ps
`default_nettype none
`include "serial_adc_defines.vh"

module serial_adc_io_sequencer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // serial pins from the host
  input  wire        cs_n,
  input  wire        io_clk,
  input  wire        data_in,
  // three-state serial data output
  output reg         data_out,
  output reg         data_out_oe,
  // conversion-done flag pin
  output reg         eoc,
  // analog core side
  input  wire [11:0] core_result,
  output reg  [3:0]  channel_select,
  output reg         sample_active,
  output reg         powered_down,
  output reg         auto_power_down
);

  // ----------------------------------------------------------------------
  // states and local constants
  // ----------------------------------------------------------------------
  localparam [0:0] ST_IO   = 1'b0;
  localparam [0:0] ST_CONV = 1'b1;
  localparam integer DEB_CYC  = `CS_DEBOUNCE_CYC;
  localparam [2:0]   DEB_LAST = DEB_CYC[2:0] - 3'h1;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // number of bits in an I/O cycle for a length field
  function [4:0] len_bits;
    input [1:0] len;
    begin
      case (len)
        `CFG_LEN_8:  len_bits = `OUT_BITS_8;
        `CFG_LEN_16: len_bits = `OUT_BITS_16;
        default:     len_bits = `OUT_BITS_12;
      endcase
    end
  endfunction

  // result arranged so that bit 15 leaves first
  function [15:0] load_word;
    input [11:0] res;
    input [1:0]  len;
    input        lsb_first;
    reg   [11:0] rev;
    integer      i;
    begin
      rev = 12'h000;
      for (i = 0; i < 12; i = i + 1) begin
        rev[i] = res[11 - i];
      end
      if (!lsb_first) begin
        load_word = {res, 4'h0};                      // 8-bit mode uses top bits only
      end else begin
        case (len)
          `CFG_LEN_8:  load_word = {rev[7:0], 8'h00};   // low four bits dropped
          `CFG_LEN_16: load_word = {4'h0, rev};         // pad bits lead when lsb first
          default:     load_word = {rev, 4'h0};
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisation and edge finding
  // ----------------------------------------------------------------------
  wire cs_s;
  wire sclk_s;
  wire din_s;
  reg  sclk_d;

  pin_sync #(
    .WIDTH (3),
    .INIT  (3'b100)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({cs_n, io_clk, data_in}),
    .sync_out ({cs_s, sclk_s, din_s})
  );

  // previous clock level, for edge detection
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;

  // ----------------------------------------------------------------------
  // chip select debounce
  // ----------------------------------------------------------------------
  reg       cs_deb;
  reg [2:0] deb_cnt;
  reg       cs_reset;

  // a level must persist for the debounce time before it is believed;
  // a short glitch therefore neither resets nor freezes the sequencer
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_deb   <= 1'b1;
      deb_cnt  <= 3'h0;
      cs_reset <= 1'b0;
    end else begin
      cs_reset <= 1'b0;
      if (cs_s == cs_deb) begin
        deb_cnt <= 3'h0;
      end else if (deb_cnt == DEB_LAST) begin
        deb_cnt  <= 3'h0;
        cs_deb   <= cs_s;
        cs_reset <= ~cs_s;                           // debounced low resets
      end else begin
        deb_cnt <= deb_cnt + 3'h1;
      end
    end
  end

  // clock edges only count while chip select is debounced low
  wire io_rise = sclk_rise & ~cs_deb;
  wire io_fall = sclk_fall & ~cs_deb;

  // ----------------------------------------------------------------------
  // conversion engine
  // ----------------------------------------------------------------------
  reg         config_format;
  reg         conv_start;
  wire        conv_busy;
  wire        conv_done;
  wire [11:0] conv_result;

  conversion_timer u_conv (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (conv_start),
    .abort       (cs_reset),
    .bipolar     (config_format),
    .core_result (core_result),
    .busy        (conv_busy),
    .done        (conv_done),
    .result      (conv_result)
  );

  // ----------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------
  reg        state;
  reg [1:0]  config_len;
  reg        config_order;
  reg [7:0]  cmd_shift;
  reg [3:0]  command_field;
  reg [4:0]  rise_cnt;
  reg [4:0]  fall_cnt;
  reg [4:0]  cycle_len;
  reg [15:0] out_shift;
  reg [11:0] out_buf;

  wire [4:0] next_rise = rise_cnt + 5'h01;
  wire [4:0] next_fall = fall_cnt + 5'h01;
  wire [3:0] cmd_at_len = cmd_shift[4:1];
  wire [3:0] cmd_at_byte = cmd_shift[6:3];
  wire       cmd_valid = (command_field <= `CMD_LAST_INPUT);

  // main I/O cycle sequencing
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state           <= ST_IO;
      config_len      <= `CFG_LEN_RESET;             // config cleared
      config_order    <= 1'b0;
      config_format   <= 1'b0;
      cmd_shift       <= 8'h00;
      command_field   <= 4'h0;
      rise_cnt        <= 5'h00;
      fall_cnt        <= 5'h00;
      cycle_len       <= `OUT_BITS_12;
      out_shift       <= 16'h0000;
      out_buf         <= 12'h000;                    // first result read is invalid
      eoc             <= 1'b1;
      conv_start      <= 1'b0;
      channel_select  <= 4'h0;
      sample_active   <= 1'b0;
      powered_down    <= 1'b1;                       // starts powered down
      auto_power_down <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (cs_reset) begin
        // reset of the I/O cycle; any conversion is dropped
        state           <= ST_IO;
        eoc             <= 1'b1;
        rise_cnt        <= 5'h00;
        fall_cnt        <= 5'h00;
        cycle_len       <= len_bits(config_len);
        out_shift       <= load_word(out_buf, config_len, config_order);
        sample_active   <= 1'b0;
        auto_power_down <= 1'b0;                     // resume on active select
      end else if (conv_done) begin
        // result latched, new cycle begins at once
        state           <= ST_IO;
        eoc             <= 1'b1;
        out_buf         <= conv_result;
        rise_cnt        <= 5'h00;
        fall_cnt        <= 5'h00;
        cycle_len       <= len_bits(config_len);
        out_shift       <= load_word(conv_result, config_len, config_order);
        auto_power_down <= 1'b1;
      end else if (state == ST_IO) begin
        if (io_rise) begin
          auto_power_down <= 1'b0;
          cmd_shift <= {cmd_shift[6:0], din_s};      // msb first on rising edge
          rise_cnt  <= next_rise;
          if (next_rise == `EDGE_LEN_TAKES && cmd_at_len != `CMD_RESERVED) begin
            cycle_len <= len_bits({cmd_shift[0], din_s});
          end
          if (next_rise == `EDGE_BYTE_DONE && cmd_at_byte != `CMD_RESERVED) begin
            config_len    <= cmd_shift[2:1];
            config_order  <= cmd_shift[0];           // used at next load
            config_format <= din_s;                  // used by this conversion
          end
        end else if (io_fall) begin
          fall_cnt <= next_fall;
          if (next_fall == `EDGE_CMD_DONE) begin
            command_field  <= cmd_shift[3:0];
            channel_select <= cmd_shift[3:0];
            if (cmd_shift[3:0] == `CMD_PWRDN) begin
              powered_down <= 1'b1;
            end else if (cmd_shift[3:0] <= `CMD_LAST_INPUT) begin
              sample_active <= 1'b1;
            end
          end
          if (next_fall == cycle_len) begin
            sample_active <= 1'b0;                   // sample held at last edge
            rise_cnt      <= 5'h00;
            fall_cnt      <= 5'h00;
            if (cmd_valid) begin
              powered_down <= 1'b0;
              state        <= ST_CONV;
              eoc          <= 1'b0;
              conv_start   <= 1'b1;
            end else begin
              // no conversion while powered down or reserved; buffer kept
              cycle_len <= len_bits(config_len);
              out_shift <= load_word(out_buf, config_len, config_order);
            end
          end else begin
            out_shift <= {out_shift[14:0], 1'b0};    // next bit on falling edge
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  // output floats one clock after the synchronised select goes high; the two-flop
  // delay on the pin is the price of a clean single clock domain
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_out    <= 1'b0;
      data_out_oe <= 1'b0;
    end else begin
      data_out_oe <= ~cs_s;
      if (state == ST_CONV || conv_busy) begin
        data_out <= 1'b0;
      end else begin
        data_out <= out_shift[15];
      end
    end
  end

endmodule // serial_adc_io_sequencer

`default_nettype wire

// >>> testbench/serial_adc_io_sequencer_monitor.sv
// assertion checker for the serial converter sequencer pins
`timescale 1ns/1ps
`default_nettype none
`include "serial_adc_defines.vh"

module serial_adc_io_sequencer_monitor (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // serial pins
  input wire logic       cs_n,
  input wire logic       data_out,
  input wire logic       data_out_oe,
  input wire logic       eoc,
  // core side
  input wire logic [3:0] channel_select,
  input wire logic       sample_active,
  input wire logic       powered_down,
  input wire logic       auto_power_down
);
  // --------------------
  // conversion timing
  // --------------------
  localparam int CONV = `CONV_CYC;
  logic [7:0] low_cnt;
  logic       aborted;

  // low cycles of the done flag; a deselect ends a conversion early, so skip those
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_cnt <= 8'h00;
      aborted <= 1'b0;
    end else if (eoc) begin
      low_cnt <= 8'h00;
      aborted <= 1'b0;
    end else begin
      low_cnt <= low_cnt + 8'h01;
      aborted <= aborted | cs_n;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_conv_short: assert property ($rose(eoc) && !aborted |-> low_cnt >= CONV - 3)
    else $error("conversion ended early");
  a_conv_long: assert property (!eoc && !aborted |-> low_cnt <= CONV + 3)
    else $error("conversion overran");
  a_low_converting: assert property (!eoc && $past(!eoc) && data_out_oe |-> !data_out)
    else $error("data not low while converting");
  a_oe_release: assert property (cs_n [*4] |=> !data_out_oe)
    else $error("output still driven while deselected");
  a_oe_select: assert property (!cs_n [*5] |=> data_out_oe)
    else $error("output not driven while selected");
  a_pd_entry: assert property ($rose(powered_down) |-> channel_select == 4'he)
    else $error("power-down without its command");
  a_sample_input: assert property (sample_active |-> channel_select <= 4'hd && eoc)
    else $error("sampling on a non-input code or flag low");
  a_sample_end: assert property ($fell(sample_active) && !cs_n |-> ##[0:2] !eoc)
    else $error("flag did not drop at end of sampling");
  a_no_conv_pd: assert property ($fell(eoc) |-> ##[0:2] !powered_down)
    else $error("conversion while powered down");
  a_auto_pd: assert property ($rose(eoc) && !aborted && !cs_n |-> ##[0:8] auto_power_down)
    else $error("no automatic power-down after conversion");
endmodule // serial_adc_io_sequencer_monitor

bind serial_adc_io_sequencer serial_adc_io_sequencer_monitor u_monitor (
  .clk_sys        (clk_sys),
  .rst            (rst),
  .cs_n           (cs_n),
  .data_out       (data_out),
  .data_out_oe    (data_out_oe),
  .eoc            (eoc),
  .channel_select (channel_select),
  .sample_active  (sample_active),
  .powered_down   (powered_down),
  .auto_power_down(auto_power_down)
);
`default_nettype wire

// >>> testbench/host_port.sv
// host serial port model: chip select, I/O clock and command data
`timescale 1ns/1ps
`default_nettype none

module host_port (
  // pins towards the converter
  output logic      cs_n,
  output logic      io_clk,
  output logic      data_in,
  // converter data pin
  input  wire logic data_out,
  input  wire logic data_out_oe
);
  // idle: deselected, clock parked low between frames
  initial begin
    cs_n = 1'b1;
    io_clk = 1'b0;
    data_in = 1'b0;
  end

  // deselect, reselect, then hold the clock low well past the debounce
  task automatic select();
    #3;
    cs_n = 1'b1;
    data_in = ~data_in; // nobody listens while deselected
    #400;
    cs_n = 1'b0;
    #400;
  endtask

  // exactly n clocks; read each bit just before the fall that replaces it
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #7;
    for (int i = 0; i < n; i++) begin
      data_in = (i < 8) ? cmd[7 - i] : cmd[0];
      #163;
      io_clk = 1'b1;
      #147;
      rx = {rx[14:0], data_out_oe ? data_out : 1'bx};
      #10;
      io_clk = 1'b0;
    end
  endtask
endmodule // host_port
`default_nettype wire

// >>> testbench/serial_adc_io_sequencer_tb.sv
// self-checking bench for the serial converter sequencer
`timescale 1ns/1ps
`default_nettype none

module serial_adc_io_sequencer_tb;
  // --------------------
  // pins, model, counters
  // --------------------
  logic        clk_sys;
  logic        rst;
  logic [11:0] core_result;
  wire logic   cs_n, io_clk, data_in;
  logic        data_out, data_out_oe, eoc, sample_active, powered_down, auto_power_down;
  logic [3:0]  channel_select;
  logic [11:0] buf_res = 12'h000;
  logic [1:0]  cfg_len = 2'b00;
  logic        cfg_lsb = 1'b0;
  logic        cfg_fmt = 1'b0;
  logic        exp_pd = 1'b1;
  int          fails = 0;
  int          checks_done = 0;
  logic [31:0] seed = 32'd50;
  logic [7:0]  cmds [14] = '{8'h00, 8'h3d, 8'h56, 8'h77, 8'h94, 8'hb8, 8'hcf,
                             8'hdf, 8'hec, 8'hf5, 8'ha0, 8'h10, 8'h20, 8'h00};

  serial_adc_io_sequencer dut (
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .io_clk(io_clk), .data_in(data_in),
    .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc), .core_result(core_result),
    .channel_select(channel_select), .sample_active(sample_active),
    .powered_down(powered_down), .auto_power_down(auto_power_down)
  );
  host_port host (
    .cs_n(cs_n), .io_clk(io_clk), .data_in(data_in),
    .data_out(data_out), .data_out_oe(data_out_oe)
  );

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // bounded wait on the done flag, sampled mid-cycle where it has settled
  task automatic wait_eoc(input logic v);
    int t;
    t = 0;
    while (eoc !== v && t < 400) begin
      @(negedge clk_sys);
      t++;
    end
    chk("eoc", {15'h0000, v}, {15'h0000, eoc});
  endtask

  // one I/O cycle against the model; entry 11 is aborted by a deselect mid-conversion
  task automatic run(input int i);
    logic [7:0]  c;
    logic [15:0] got;
    logic [15:0] exp;
    logic [31:0] r;
    int          n;
    int          k;
    c = cmds[i];
    r = xs();
    if (c[7:4] != 4'hf) cfg_len = c[3:2];
    n = (cfg_len == 2'b01) ? 8 : (cfg_len == 2'b11) ? 16 : 12;
    exp = 16'h0000;
    for (int b = 0; b < n; b++) begin
      k = cfg_lsb ? b + ((n == 8) ? 4 : 0) - ((n == 16) ? 4 : 0) : 11 - b;
      exp = {exp[14:0], (k < 0) ? 1'b0 : buf_res[k]};
    end
    @(posedge clk_sys);
    core_result <= (i == 1) ? 12'hfff : (i == 6) ? 12'h000 : r[11:0];
    host.xfer(c, n, got);
    chk("data_out", exp, got);
    chk("channel", {12'h000, c[7:4]}, {12'h000, channel_select});
    if (c[7:4] != 4'hf) begin
      cfg_lsb = c[1]; // order only counts from the next cycle
      cfg_fmt = c[0];
    end
    if (c[7:4] == 4'he) exp_pd = 1'b1;
    if (c[7:4] < 4'he) begin
      wait_eoc(1'b0);
      if (i == 11) begin
        repeat (20) @(posedge clk_sys);
        host.select();
      end else begin
        wait_eoc(1'b1);
        buf_res = cfg_fmt ? core_result ^ 12'h800 : core_result;
        exp_pd = 1'b0;
        repeat (4) @(posedge clk_sys);
      end
    end else begin
      host.select();
    end
    chk("powered_down", {15'h0000, exp_pd}, {15'h0000, powered_down});
    $display("test %0d command %h done", i, c);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    core_result = 12'h000;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("eoc", 16'h0001, {15'h0000, eoc});
    host.select();
    for (int i = 0; i < 14; i++) run(i);
    final_report();
  end

  // watchdog: the table needs about 110 us
  initial begin
    #1000000;
    fails++;
    final_report();
  end
endmodule // serial_adc_io_sequencer_tb
`default_nettype wire
